// file: include/puc_pkg.sv
// constants and types shared by the power-up configuration decoder
package puc_pkg;
  // clock and start-up timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FLASH_MIN_MS = 3000;
  localparam int FLASH_MIN_CYC = (FLASH_MIN_MS / 1000) * (1_000_000_000 / CLK_PERIOD_NS);
  localparam int BLINK_HZ = 2;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  // product variants
  localparam logic [1:0] VAR_NARROW = 2'h0;
  localparam logic [1:0] VAR_WIDE_A = 2'h1;
  localparam logic [1:0] VAR_WIDE_B = 2'h2;
  // fixed address prefix and defaults
  localparam logic [7:0] IP_OCT0 = 8'hAC;
  localparam logic [7:0] IP_OCT1 = 8'h10;
  localparam logic [7:0] IP_OCT2_NARROW = 8'h15;
  localparam logic [7:0] IP_OCT2_WIDE_A = 8'h16;
  localparam logic [7:0] IP_OCT2_WIDE_B = 8'h17;
  localparam logic [31:0] FIXED_MASK = 32'hFFFF0000;
  localparam logic [31:0] FIXED_GW = 32'h00000000;
  localparam logic [7:0] ADDR_ALL_OFF = 8'h00;
  localparam logic [7:0] ADDR_ALL_ON = 8'hFF;
  // maintenance codes
  localparam logic [7:0] CODE_FACTORY = 8'h63;
  localparam logic [7:0] CODE_DEL_BOOT = 8'h62;
  localparam logic [7:0] CODE_DEL_CFG = 8'h61;
  // error classes, one led each
  localparam int ERR_W = 3;
  localparam int ERR_BUS = 0;
  localparam int ERR_CFG = 1;
  localparam int ERR_SWITCH = 2;
  // addressing methods
  typedef enum logic [2:0] {
    PUC_ADDR_NONE,
    PUC_ADDR_FIXED,
    PUC_ADDR_BOOTP,
    PUC_ADDR_BOOTP_SAVE,
    PUC_ADDR_DHCP,
    PUC_ADDR_REMOTE
  } puc_addr_t;
  // maintenance actions
  typedef enum logic [1:0] {
    PUC_ACT_NONE,
    PUC_ACT_FACTORY,
    PUC_ACT_DEL_BOOT,
    PUC_ACT_DEL_CFG
  } puc_act_t;
endpackage : puc_pkg

// file: core/puc_sync.sv
// two flip-flop synchroniser for a vector of slow pins
`timescale 1ns/10ps
`default_nettype none
module puc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = d_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_o = sync_r;
endmodule : puc_sync
`default_nettype wire

// file: core/puc_top.sv
// power-up switch sampling, mode decode, start-up sequencing and led indication
// How it works
// - after reset the block checks state, sets up the terminal bus, builds the list, then runs.
// - io leds flash during start-up and stop after at least the minimum time when error free.
// - on a start-up error the led that flashes is the one of that error class.
// - a bad stored configuration lights its indication and a readable status bit.
// - io terminals present selects addressing mode, end terminal only selects configuration mode.
// - address switches one to eight give the last ip address byte.
// - on the narrow variant the two-position switch selects the method, right reads as on.
// - on wide variants switches nine and ten select the method, with inverted polarity.
// - both selector bits off gives a fixed address, mask 255.255.0.0 and gateway zero.
// - the fixed third octet is 21, 22 or 23 according to variant.
// - first bit on only selects bootp, plain with all switches off, with save with all on.
// - second bit on only selects dhcp, both on take settings from the management tool.
// - configuration mode decodes the switches as binary: 99 factory, 98 boot, 97 config.
// - bootp with save requests a non-volatile store unless BOOTP_SAVED_I says one is already stored, and skips later queries.
`timescale 1ns/10ps
`default_nettype none
module puc_top #(
  parameter logic [1:0] VARIANT = puc_pkg::VAR_NARROW,
  parameter int FLASH_CYC = puc_pkg::FLASH_MIN_CYC,
  parameter int BLINK_CYC = puc_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // operator switches, raw pins; switch level is high in the right position
  input wire logic [7:0] ADDR_SW_I,
  input wire logic MODE_SELECT_BIT_A_I,
  input wire logic MODE_SELECT_BIT_B_I,
  input wire logic WIDE_MODE_SELECT_BIT_A_I,
  input wire logic WIDE_MODE_SELECT_BIT_B_I,
  // terminal bus handshake, same clock domain
  input wire logic BUS_INIT_DONE_I,
  input wire logic BUS_IO_PRESENT_I,
  input wire logic BUS_ERR_I,
  input wire logic CFG_VALID_I,
  input wire logic BOOTP_SAVED_I,
  output logic BUS_INIT_START_O,
  // decoded configuration
  output logic ADDR_MODE_O,
  output logic [2:0] ADDR_METHOD_O,
  output logic [31:0] IP_ADDR_O,
  output logic [31:0] SUBNET_MASK_O,
  output logic [31:0] GATEWAY_O,
  output logic NV_STORE_IP_O,
  output logic [1:0] MAINT_ACTION_O,
  output logic MAINT_GO_O,
  output logic PLC_RUN_O,
  // indication and status
  output logic IO_LED_O,
  output logic [2:0] ERR_LED_O,
  output logic CFG_FAULT_O
);
  typedef enum logic [2:0] {
    PUC_ST_SAMPLE,
    PUC_ST_BUSINIT,
    PUC_ST_LIST,
    PUC_ST_WAIT,
    PUC_ST_RUN,
    PUC_ST_ERROR
  } puc_state_t;

  logic [7:0] sw_s;
  logic [3:0] sel_s;

  puc_sync #(
    .W(12)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .d_i({WIDE_MODE_SELECT_BIT_B_I, WIDE_MODE_SELECT_BIT_A_I,
          MODE_SELECT_BIT_B_I, MODE_SELECT_BIT_A_I, ADDR_SW_I}),
    .q_o({sel_s, sw_s})
  );

  puc_state_t st_r, st_nxt;
  logic [1:0] settle_r, settle_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic sel_a_r, sel_a_nxt;
  logic sel_b_r, sel_b_nxt;
  logic [31:0] flash_cnt_r, flash_cnt_nxt;
  logic [31:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_r, blink_nxt;
  logic addr_mode_r, addr_mode_nxt;
  logic [2:0] method_r, method_nxt;
  logic [31:0] ip_r, ip_nxt;
  logic [31:0] mask_r, mask_nxt;
  logic [31:0] gw_r, gw_nxt;
  logic nv_r, nv_nxt;
  logic [1:0] act_r, act_nxt;
  logic go_r, go_nxt;
  logic run_r, run_nxt;
  logic init_r, init_nxt;
  logic io_led_r, io_led_nxt;
  logic [2:0] err_led_r, err_led_nxt;
  logic [2:0] err_cls_r, err_cls_nxt;
  logic fault_r, fault_nxt;
  logic flash_done;
  logic [7:0] oct2;

  // variant picks the fixed third address octet
  always_comb
  begin
    case (VARIANT)
      puc_pkg::VAR_WIDE_A: oct2 = puc_pkg::IP_OCT2_WIDE_A;
      puc_pkg::VAR_WIDE_B: oct2 = puc_pkg::IP_OCT2_WIDE_B;
      default: oct2 = puc_pkg::IP_OCT2_NARROW;
    endcase
  end

  assign flash_done = (flash_cnt_r >= 32'(FLASH_CYC));

  always_comb
  begin
    st_nxt = st_r;
    settle_nxt = settle_r;
    addr_nxt = addr_r;
    sel_a_nxt = sel_a_r;
    sel_b_nxt = sel_b_r;
    flash_cnt_nxt = flash_cnt_r;
    addr_mode_nxt = addr_mode_r;
    method_nxt = method_r;
    ip_nxt = ip_r;
    mask_nxt = mask_r;
    gw_nxt = gw_r;
    nv_nxt = nv_r;
    act_nxt = act_r;
    go_nxt = 1'b0;
    run_nxt = run_r;
    init_nxt = 1'b0;
    err_cls_nxt = err_cls_r;
    fault_nxt = fault_r;
    if (!flash_done)
      flash_cnt_nxt = flash_cnt_r + 32'h1;
    case (st_r)
      PUC_ST_SAMPLE:
      begin
        // wait for the synchroniser to fill, then capture once
        settle_nxt = settle_r + 2'h1;
        if (settle_r == 2'h3)
        begin
          addr_nxt = sw_s;
          if (VARIANT == puc_pkg::VAR_NARROW)
          begin
            sel_a_nxt = sel_s[0];
            sel_b_nxt = sel_s[1];
          end
          else
          begin
            sel_a_nxt = ~sel_s[2];
            sel_b_nxt = ~sel_s[3];
          end
          init_nxt = 1'b1;
          st_nxt = PUC_ST_BUSINIT;
        end
      end
      PUC_ST_BUSINIT:
      begin
        if (BUS_ERR_I)
        begin
          err_cls_nxt[puc_pkg::ERR_BUS] = 1'b1;
          st_nxt = PUC_ST_ERROR;
        end
        else if (BUS_INIT_DONE_I)
        begin
          addr_mode_nxt = BUS_IO_PRESENT_I;
          st_nxt = PUC_ST_LIST;
        end
      end
      PUC_ST_LIST:
      begin
        fault_nxt = !CFG_VALID_I;
        if (!CFG_VALID_I)
          err_cls_nxt[puc_pkg::ERR_CFG] = 1'b1;
        if (addr_mode_r)
        begin
          ip_nxt = {puc_pkg::IP_OCT0, puc_pkg::IP_OCT1, oct2, addr_r};
          mask_nxt = puc_pkg::FIXED_MASK;
          gw_nxt = puc_pkg::FIXED_GW;
          case ({sel_b_r, sel_a_r})
            2'h0: method_nxt = puc_pkg::PUC_ADDR_FIXED;
            2'h1:
            begin
              if (addr_r == puc_pkg::ADDR_ALL_ON)
              begin
                method_nxt = puc_pkg::PUC_ADDR_BOOTP_SAVE;
                nv_nxt = !BOOTP_SAVED_I;
              end
              else if (addr_r == puc_pkg::ADDR_ALL_OFF)
                method_nxt = puc_pkg::PUC_ADDR_BOOTP;
              else
              begin
                method_nxt = puc_pkg::PUC_ADDR_NONE;
                err_cls_nxt[puc_pkg::ERR_SWITCH] = 1'b1;
              end
            end
            2'h2: method_nxt = puc_pkg::PUC_ADDR_DHCP;
            default: method_nxt = puc_pkg::PUC_ADDR_REMOTE;
          endcase
        end
        else
        begin
          method_nxt = puc_pkg::PUC_ADDR_NONE;
          // selectors must be off, otherwise no action is taken
          if (sel_a_r || sel_b_r)
            act_nxt = puc_pkg::PUC_ACT_NONE;
          else
            case (addr_r)
              puc_pkg::CODE_FACTORY: act_nxt = puc_pkg::PUC_ACT_FACTORY;
              puc_pkg::CODE_DEL_BOOT: act_nxt = puc_pkg::PUC_ACT_DEL_BOOT;
              puc_pkg::CODE_DEL_CFG: act_nxt = puc_pkg::PUC_ACT_DEL_CFG;
              default: act_nxt = puc_pkg::PUC_ACT_NONE;
            endcase
        end
        st_nxt = PUC_ST_WAIT;
      end
      PUC_ST_WAIT:
      begin
        // error indication outranks the normal run start
        if (err_cls_r != '0)
          st_nxt = PUC_ST_ERROR;
        else if (flash_done)
        begin
          run_nxt = 1'b1;
          go_nxt = (act_r != puc_pkg::PUC_ACT_NONE);
          st_nxt = PUC_ST_RUN;
        end
      end
      PUC_ST_RUN:
      begin
        nv_nxt = 1'b0;
      end
      PUC_ST_ERROR:
      begin
        run_nxt = 1'b0;
      end
      default: st_nxt = PUC_ST_SAMPLE;
    endcase
  end

  // led flashing runs off a divider enable
  always_comb
  begin
    blink_cnt_nxt = blink_cnt_r + 32'h1;
    blink_nxt = blink_r;
    if (blink_cnt_r >= 32'(BLINK_CYC - 1))
    begin
      blink_cnt_nxt = '0;
      blink_nxt = ~blink_r;
    end
    io_led_nxt = (st_r == PUC_ST_RUN) ? 1'b1 : blink_r;
    if (st_r == PUC_ST_ERROR)
      io_led_nxt = 1'b0;
    err_led_nxt = (st_r == PUC_ST_ERROR) ? (err_cls_r & {3{blink_r}}) : 3'h0;
    if (fault_r)
      err_led_nxt[puc_pkg::ERR_CFG] = blink_r;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_r <= PUC_ST_SAMPLE;
      settle_r <= '0;
      addr_r <= '0;
      sel_a_r <= 1'b0;
      sel_b_r <= 1'b0;
      flash_cnt_r <= '0;
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
      addr_mode_r <= 1'b0;
      method_r <= puc_pkg::PUC_ADDR_NONE;
      ip_r <= '0;
      mask_r <= '0;
      gw_r <= '0;
      nv_r <= 1'b0;
      act_r <= puc_pkg::PUC_ACT_NONE;
      go_r <= 1'b0;
      run_r <= 1'b0;
      init_r <= 1'b0;
      io_led_r <= 1'b0;
      err_led_r <= '0;
      err_cls_r <= '0;
      fault_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      settle_r <= settle_nxt;
      addr_r <= addr_nxt;
      sel_a_r <= sel_a_nxt;
      sel_b_r <= sel_b_nxt;
      flash_cnt_r <= flash_cnt_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= blink_nxt;
      addr_mode_r <= addr_mode_nxt;
      method_r <= method_nxt;
      ip_r <= ip_nxt;
      mask_r <= mask_nxt;
      gw_r <= gw_nxt;
      nv_r <= nv_nxt;
      act_r <= act_nxt;
      go_r <= go_nxt;
      run_r <= run_nxt;
      init_r <= init_nxt;
      io_led_r <= io_led_nxt;
      err_led_r <= err_led_nxt;
      err_cls_r <= err_cls_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign BUS_INIT_START_O = init_r;
  assign ADDR_MODE_O = addr_mode_r;
  assign ADDR_METHOD_O = method_r;
  assign IP_ADDR_O = ip_r;
  assign SUBNET_MASK_O = mask_r;
  assign GATEWAY_O = gw_r;
  assign NV_STORE_IP_O = nv_r;
  assign MAINT_ACTION_O = act_r;
  assign MAINT_GO_O = go_r;
  assign PLC_RUN_O = run_r;
  assign IO_LED_O = io_led_r;
  assign ERR_LED_O = err_led_r;
  assign CFG_FAULT_O = fault_r;

  run_after_list_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $rose(run_r) |-> $past(st_r) == PUC_ST_WAIT && flash_done)
    else $error("run started before list and flash time");
  run_not_early_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    run_r |-> flash_cnt_r >= 32'(FLASH_CYC))
    else $error("run before minimum flash time");
  err_led_class_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (st_r == PUC_ST_ERROR && !fault_r) |=> (err_led_r & ~err_cls_r) == 3'h0)
    else $error("error led outside its class");
  cfg_fault_led_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    fault_r |=> err_led_r[puc_pkg::ERR_CFG] == $past(blink_r))
    else $error("config fault not indicated");
  mode_pick_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (st_r == PUC_ST_BUSINIT && BUS_INIT_DONE_I && !BUS_ERR_I)
      |=> addr_mode_r == $past(BUS_IO_PRESENT_I))
    else $error("mode not taken from bus presence");
  fixed_addr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    method_r == puc_pkg::PUC_ADDR_FIXED |-> ip_r[7:0] == addr_r
      && ip_r[15:8] == oct2 && mask_r == puc_pkg::FIXED_MASK)
    else $error("fixed address wrong");
  bootp_sel_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (method_r == puc_pkg::PUC_ADDR_BOOTP || method_r == puc_pkg::PUC_ADDR_BOOTP_SAVE)
      |-> sel_a_r && !sel_b_r)
    else $error("bootp chosen with wrong selector");
  maint_code_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    act_r == puc_pkg::PUC_ACT_FACTORY |-> addr_r == puc_pkg::CODE_FACTORY
      && !addr_mode_r)
    else $error("factory action without code 99");
  sample_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_r != PUC_ST_SAMPLE |=> $stable(addr_r) && $stable(sel_a_r))
    else $error("switch sample changed after power-up");
endmodule : puc_top
`default_nettype wire

// file: bench/puc_bus_model.sv
// terminal bus responder that answers a start request with one setup result
`timescale 1ns/10ps
`default_nettype none
module puc_bus_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // scenario control
  input wire logic io_cfg_i,
  input wire logic err_cfg_i,
  input wire logic [7:0] delay_i,
  // terminal bus side
  input wire logic start_i,
  output logic done_o,
  output logic io_present_o,
  output logic err_o
);
  logic [7:0] cnt_r;
  logic busy_r;
  logic io_r;
  logic wander_r;
  // one answer per reset, after a prompt or slow delay; error replaces done
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      io_r <= 1'b0;
      wander_r <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      wander_r <= ~wander_r;
      if (start_i && !busy_r && !done_o && !err_o)
      begin
        busy_r <= 1'b1;
        cnt_r <= 8'h00;
      end
      else if (busy_r)
      begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == delay_i)
        begin
          busy_r <= 1'b0;
          done_o <= !err_cfg_i;
          err_o <= err_cfg_i;
          io_r <= io_cfg_i;
        end
      end
    end
  end
  // presence means nothing before the result, so it wanders instead of holding
  assign io_present_o = (done_o || err_o) ? io_r : wander_r;
endmodule : puc_bus_model
`default_nettype wire

// file: bench/puc_top_tb.sv
// self-checking bench: one power-up pass per scenario
`timescale 1ns/10ps
`default_nettype none
module puc_top_tb;
  localparam int FLASH = 200;
  logic clk;
  logic rst_n;
  logic [7:0] addr_sw;
  logic sel_a;
  logic sel_b;
  logic wsel_a;
  logic wsel_b;
  logic bus_done;
  logic bus_io;
  logic bus_err;
  logic io_cfg;
  logic err_cfg;
  logic cfg_valid;
  logic saved;
  logic [7:0] dly;
  logic bus_start;
  logic addr_mode;
  logic [2:0] addr_meth;
  logic [31:0] ip_addr;
  logic [31:0] mask;
  logic [31:0] gw;
  logic nv_store;
  logic [1:0] act_o;
  logic go_o;
  logic run_o;
  logic io_led;
  logic [2:0] err_led;
  logic cfg_fault;
  int err_total;
  int checked;
  logic [2:0] w_meth;
  logic [31:0] w_ip;
  logic [1:0] w_act;
  logic w_run;
  puc_top #(.VARIANT(puc_pkg::VAR_NARROW), .FLASH_CYC(FLASH), .BLINK_CYC(4)) dut_u (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_SW_I(addr_sw),
    .MODE_SELECT_BIT_A_I(sel_a), .MODE_SELECT_BIT_B_I(sel_b),
    .WIDE_MODE_SELECT_BIT_A_I(wsel_a), .WIDE_MODE_SELECT_BIT_B_I(wsel_b),
    .BUS_INIT_DONE_I(bus_done), .BUS_IO_PRESENT_I(bus_io), .BUS_ERR_I(bus_err),
    .CFG_VALID_I(cfg_valid), .BOOTP_SAVED_I(saved), .BUS_INIT_START_O(bus_start),
    .ADDR_MODE_O(addr_mode), .ADDR_METHOD_O(addr_meth), .IP_ADDR_O(ip_addr),
    .SUBNET_MASK_O(mask), .GATEWAY_O(gw), .NV_STORE_IP_O(nv_store),
    .MAINT_ACTION_O(act_o), .MAINT_GO_O(go_o), .PLC_RUN_O(run_o), .IO_LED_O(io_led),
    .ERR_LED_O(err_led), .CFG_FAULT_O(cfg_fault));
  puc_bus_model bus_u (
    .clk_i(clk), .rst_n_i(rst_n), .io_cfg_i(io_cfg), .err_cfg_i(err_cfg), .delay_i(dly),
    .start_i(bus_start), .done_o(bus_done), .io_present_o(bus_io), .err_o(bus_err));
  // wide variant beside the narrow one: same bus answer, inverted selector pins
  puc_top #(.VARIANT(puc_pkg::VAR_WIDE_A), .FLASH_CYC(FLASH), .BLINK_CYC(4)) dut_w_u (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_SW_I(addr_sw),
    .MODE_SELECT_BIT_A_I(sel_a), .MODE_SELECT_BIT_B_I(sel_b),
    .WIDE_MODE_SELECT_BIT_A_I(wsel_a), .WIDE_MODE_SELECT_BIT_B_I(wsel_b),
    .BUS_INIT_DONE_I(bus_done), .BUS_IO_PRESENT_I(bus_io), .BUS_ERR_I(bus_err),
    .CFG_VALID_I(cfg_valid), .BOOTP_SAVED_I(saved), .BUS_INIT_START_O(),
    .ADDR_MODE_O(), .ADDR_METHOD_O(w_meth), .IP_ADDR_O(w_ip), .SUBNET_MASK_O(),
    .GATEWAY_O(), .NV_STORE_IP_O(), .MAINT_ACTION_O(w_act), .MAINT_GO_O(),
    .PLC_RUN_O(w_run), .IO_LED_O(), .ERR_LED_O(), .CFG_FAULT_O());
  task automatic step();
    @(posedge clk);
    #2;
  endtask : step
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_vec
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // one full power-up; switches are flipped once captured to prove they are ignored
  task automatic boot(input logic [7:0] sw, input logic a, input logic b, input logic io,
    input logic be, input logic cv, input logic [2:0] meth, input logic [1:0] act,
    input logic [2:0] eled, input logic run);
    int n;
    int starts;
    int gos;
    int run_at;
    logic [2:0] eseen;
    logic io_hi;
    logic io_lo;
    logic nv;
    rst_n = 1'b0;
    dly = (dly == 8'h00) ? 8'h14 : 8'h00;
    addr_sw = sw;
    sel_a = a;
    sel_b = b;
    wsel_a = ~a;
    wsel_b = ~b;
    io_cfg = io;
    err_cfg = be;
    cfg_valid = cv;
    starts = 0;
    gos = 0;
    run_at = -1;
    eseen = 3'h0;
    io_hi = 1'b0;
    io_lo = 1'b0;
    nv = 1'b0;
    repeat (16) step();
    rst_n = 1'b1;
    for (n = 0; n < FLASH * 5 / 3 + 40; n++)
    begin
      step();
      if (bus_start === 1'b1)
      begin
        starts++;
        addr_sw = ~sw;
        sel_a = ~a;
        sel_b = ~b;
        wsel_a = a;
        wsel_b = b;
      end
      if (go_o === 1'b1) gos++;
      if (nv_store === 1'b1) nv = 1'b1;
      if (run_o === 1'b1 && run_at < 0) run_at = n;
      if (run_at < 0 && io_led === 1'b1) io_hi = 1'b1;
      if (run_at < 0 && io_led === 1'b0) io_lo = 1'b1;
      eseen = eseen | err_led;
    end
    chk_vec(32'(starts), 32'h1);
    chk_bit(run_o, run);
    chk_vec({29'h0, eseen}, {29'h0, eled});
    chk_bit(io_hi && io_lo, 1'b1);
    if (!be) chk_bit(addr_mode, io);
    if (!be) chk_bit(cfg_fault, ~cv);
    if (!be) chk_vec({30'h0, act_o}, {30'h0, act});
    if (io && !be) chk_vec({29'h0, addr_meth}, {29'h0, meth});
    if (io && !be) chk_bit(nv, meth == puc_pkg::PUC_ADDR_BOOTP_SAVE && !saved);
    if (io && !be) chk_vec({29'h0, w_meth}, {29'h0, meth});
    if (!be) chk_vec({30'h0, w_act}, {30'h0, act});
    chk_bit(w_run, run);
    if (meth == puc_pkg::PUC_ADDR_FIXED && cv)
    begin
      chk_vec(ip_addr, {puc_pkg::IP_OCT0, puc_pkg::IP_OCT1, puc_pkg::IP_OCT2_NARROW, sw});
      chk_vec(w_ip, {puc_pkg::IP_OCT0, puc_pkg::IP_OCT1, puc_pkg::IP_OCT2_WIDE_A, sw});
      chk_vec(mask, 32'hFFFF0000);
      chk_vec(gw, 32'h00000000);
    end
    if (run)
    begin
      chk_bit(run_at >= FLASH - 2 && run_at <= FLASH * 5 / 3, 1'b1);
      chk_bit(io_led, 1'b1);
      chk_vec(32'(gos), (act != 2'h0) ? 32'h1 : 32'h0);
    end
    else
    begin
      chk_bit(io_led, 1'b0);
    end
  endtask : boot
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("mismatch %0t run did not finish in time", $time);
    tally_and_finish();
  end
  initial
  begin
    err_total = 0;
    checked = 0;
    rst_n = 1'b0;
    addr_sw = 8'h00;
    sel_a = 1'b0;
    sel_b = 1'b0;
    wsel_a = 1'b1;
    wsel_b = 1'b1;
    io_cfg = 1'b1;
    err_cfg = 1'b0;
    cfg_valid = 1'b1;
    saved = 1'b0;
    dly = 8'h00;
    boot(8'h5A, 0, 0, 1, 0, 1, puc_pkg::PUC_ADDR_FIXED, 2'h0, 3'h0, 1);
    boot(8'h00, 1, 0, 1, 0, 1, puc_pkg::PUC_ADDR_BOOTP, 2'h0, 3'h0, 1);
    boot(8'hFF, 1, 0, 1, 0, 1, puc_pkg::PUC_ADDR_BOOTP_SAVE, 2'h0, 3'h0, 1);
    boot(8'h12, 1, 0, 1, 0, 1, puc_pkg::PUC_ADDR_NONE, 2'h0, 3'h4, 0);
    boot(8'h5A, 0, 1, 1, 0, 1, puc_pkg::PUC_ADDR_DHCP, 2'h0, 3'h0, 1);
    boot(8'h5A, 1, 1, 1, 0, 1, puc_pkg::PUC_ADDR_REMOTE, 2'h0, 3'h0, 1);
    // configuration mode with both selector bits off, then code 99 with the second bit on for no action
    boot(8'h63, 0, 0, 0, 0, 1, puc_pkg::PUC_ADDR_NONE, 2'h1, 3'h0, 1);
    boot(8'h62, 0, 0, 0, 0, 1, puc_pkg::PUC_ADDR_NONE, 2'h2, 3'h0, 1);
    boot(8'h61, 0, 0, 0, 0, 1, puc_pkg::PUC_ADDR_NONE, 2'h3, 3'h0, 1);
    boot(8'h64, 0, 0, 0, 0, 1, puc_pkg::PUC_ADDR_NONE, 2'h0, 3'h0, 1);
    boot(8'h63, 0, 1, 0, 0, 1, puc_pkg::PUC_ADDR_NONE, 2'h0, 3'h0, 1);
    boot(8'h5A, 0, 0, 1, 1, 1, puc_pkg::PUC_ADDR_NONE, 2'h0, 3'h1, 0);
    boot(8'h5A, 0, 0, 1, 0, 0, puc_pkg::PUC_ADDR_FIXED, 2'h0, 3'h2, 0);
    // an address already saved needs no new store request
    saved = 1'b1;
    boot(8'hFF, 1, 0, 1, 0, 1, puc_pkg::PUC_ADDR_BOOTP_SAVE, 2'h0, 3'h0, 1);
    saved = 1'b0;
    tally_and_finish();
  end
endmodule : puc_top_tb
`default_nettype wire
